//--- common/aocal_pkg.sv
package aocal_pkg;
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFS_LOW_ADDR = 3'h0;
  localparam logic [2:0] OFS_MID_ADDR = 3'h1;
  localparam logic [2:0] OFS_HIGH_ADDR = 3'h2;
  localparam logic [2:0] GAIN_LOW_ADDR = 3'h3;
  localparam logic [2:0] GAIN_MID_ADDR = 3'h4;
  localparam logic [2:0] GAIN_HIGH_ADDR = 3'h5;
  localparam logic [23:0] OFS_RESET = 24'h00_0000;
  localparam logic [23:0] GAIN_UNITY = 24'h40_0000;
  localparam int GAIN_FRAC_BITS = 22;
  localparam int OFS_SUB_BITS = 8;
  localparam logic [15:0] CODE_POS_FS = 16'h7fff;
  localparam logic [15:0] CODE_NEG_FS = 16'h8000;
  localparam int CAL_CONVERSIONS = 16;
  localparam int CAL_AVG_SHIFT = 4;
  localparam int CAL_SYSCLK_PERIODS = 50;
  localparam int CAL_MODCLK_PERIODS = 32;
  localparam int CLK_SYS_MHZ = 250;
  localparam int CLK_SYS_PERIOD_NS = 4;
  typedef enum logic [1:0] {
    AOCAL_CMD_NONE,
    AOCAL_CMD_SYS_OFS,
    AOCAL_CMD_SELF_OFS,
    AOCAL_CMD_SYS_GAIN
  } aocal_cmd_t;
  typedef enum {
    AOCAL_IDLE,
    AOCAL_SETTLE,
    AOCAL_MOD,
    AOCAL_ACCUM,
    AOCAL_STORE
  } aocal_state_t;
endpackage : aocal_pkg

//--- core/aocal_regs.sv
module aocal_regs
  import aocal_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic [aocal_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic cal_ofs_load,
  input wire logic cal_gain_load,
  input wire logic [23:0] cal_value,
  output logic [23:0] offset_correction_word,
  output logic [23:0] gain_correction_word
);
  wire logic [23:0] next_ofs;
  wire logic [23:0] next_gain;

  function automatic logic [23:0] byte_merge(input logic [23:0] word,
      input logic [1:0] idx, input logic [7:0] data);
    logic [23:0] res;
    res = word;
    res[idx*8 +: 8] = data;
    return res;
  endfunction : byte_merge

  // calibration result overrides a host write in the same cycle
  assign next_ofs = cal_ofs_load ? cal_value :
    (reg_wr && reg_addr <= OFS_HIGH_ADDR) ?
    byte_merge(offset_correction_word, reg_addr[1:0], reg_wdata) :
    offset_correction_word;
  assign next_gain = cal_gain_load ? cal_value :
    (reg_wr && reg_addr >= GAIN_LOW_ADDR && reg_addr <= GAIN_HIGH_ADDR) ?
    byte_merge(gain_correction_word, 2'(reg_addr - GAIN_LOW_ADDR),
    reg_wdata) : gain_correction_word;

  always_comb begin
    unique case (reg_addr)
      OFS_LOW_ADDR: reg_rdata = offset_correction_word[7:0];
      OFS_MID_ADDR: reg_rdata = offset_correction_word[15:8];
      OFS_HIGH_ADDR: reg_rdata = offset_correction_word[23:16];
      GAIN_LOW_ADDR: reg_rdata = gain_correction_word[7:0];
      GAIN_MID_ADDR: reg_rdata = gain_correction_word[15:8];
      GAIN_HIGH_ADDR: reg_rdata = gain_correction_word[23:16];
      default: reg_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      offset_correction_word <= OFS_RESET;
      gain_correction_word <= GAIN_UNITY;
    end else begin
      offset_correction_word <= next_ofs;
      gain_correction_word <= next_gain;
    end
  end
endmodule : aocal_regs

//--- core/aocal_scaler.sv
module aocal_scaler
  import aocal_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [15:0] in_data,
  input wire logic [23:0] offset_correction_word,
  input wire logic [23:0] gain_correction_word,
  output logic out_valid,
  output logic [15:0] out_data
);
  // full-width diff, then product, then clip to 16 bits
  // sub-lsb byte kept so the floor lands on the documented codes
  wire logic signed [24:0] diff;
  wire logic signed [49:0] prod;
  wire logic signed [49:0] scaled;
  wire logic [15:0] clipped;

  assign diff = $signed({in_data[15], in_data, 8'h00})
    - $signed({offset_correction_word[23], offset_correction_word});
  assign prod = 50'(diff)
    * $signed({26'h000_0000, gain_correction_word});
  assign scaled = prod >>> (GAIN_FRAC_BITS + OFS_SUB_BITS);
  assign clipped = (scaled > 50'sd32767) ? CODE_POS_FS :
    (scaled < -50'sd32768) ? CODE_NEG_FS : scaled[15:0];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data <= 16'h0000;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        out_data <= clipped;
      end
    end
  end
endmodule : aocal_scaler

//--- core/aocal_top.sv
module aocal_top
  import aocal_pkg::*;
#(
  parameter int MOD_DIV = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic [aocal_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic system_offset_cal_cmd,
  input wire logic internal_offset_cal_cmd,
  input wire logic system_gain_cal_cmd,
  input wire logic sleep_cmd,
  input wire logic start_pin,
  input wire logic mod_tick,
  input wire logic filt_valid,
  input wire logic [15:0] filt_data,
  output logic filt_restart,
  output logic input_short_mid,
  output logic cal_busy,
  output logic power_down,
  output logic result_valid,
  output logic [15:0] result_data,
  output logic conversion_ready_n,
  input wire logic ready_clear
);
  initial begin
    if (MOD_DIV < 1) begin
      $error("MOD_DIV must be at least one");
    end
  end

  aocal_state_t state;
  aocal_state_t next_state;
  aocal_cmd_t cal_kind;
  logic [5:0] settle_cnt;
  logic [5:0] mod_cnt;
  logic [4:0] conv_cnt;
  logic signed [19:0] acc;
  logic pd_pending;
  logic [2:0] start_sync;
  logic start_level;
  logic [23:0] cal_value;
  logic cal_ofs_load;
  logic cal_gain_load;
  logic scaled_valid;
  logic [15:0] scaled_data;
  logic [23:0] offset_correction_word;
  logic [23:0] gain_correction_word;

  wire logic any_cmd;
  wire logic start_fall;
  wire logic settle_done;
  wire logic mod_done;
  wire logic accum_done;
  wire logic signed [15:0] avg;
  wire logic [23:0] gain_value;
  wire logic calibrating;

  // averages sixteen samples by arithmetic shift
  function automatic logic signed [15:0] avg_of(input logic signed [19:0] a);
    logic signed [19:0] s;
    s = a >>> CAL_AVG_SHIFT;
    return s[15:0];
  endfunction : avg_of

  // gain that maps the averaged full-scale reading to positive full scale
  function automatic logic [23:0] gain_for(input logic signed [15:0] v);
    logic [39:0] num;
    logic [39:0] q;
    num = {24'h00_0000, CODE_POS_FS} << GAIN_FRAC_BITS;
    if (v <= 16'sh0000) begin
      q = {16'h0000, GAIN_UNITY};
    end else begin
      q = num / {24'h00_0000, v};
    end
    if (q > 40'h00_00ff_ffff) begin
      q = 40'h00_00ff_ffff;
    end
    return q[23:0];
  endfunction : gain_for

  assign any_cmd = system_offset_cal_cmd | internal_offset_cal_cmd
    | system_gain_cal_cmd;
  assign start_fall = start_level & ~start_sync[1] & ~start_sync[2];
  assign settle_done = settle_cnt == 6'(CAL_SYSCLK_PERIODS - 1);
  assign mod_done = mod_tick && mod_cnt == 6'(CAL_MODCLK_PERIODS - 1);
  assign accum_done = filt_valid && conv_cnt == 5'(CAL_CONVERSIONS - 1);
  assign avg = avg_of(acc + 20'(signed'(filt_data)));
  assign gain_value = gain_for(avg);
  assign calibrating = state != AOCAL_IDLE;

  always_comb begin
    next_state = state;
    unique case (state)
      AOCAL_IDLE: begin
        if (any_cmd) begin
          next_state = AOCAL_SETTLE;
        end
      end
      AOCAL_SETTLE: begin
        if (settle_done) begin
          next_state = AOCAL_MOD;
        end
      end
      AOCAL_MOD: begin
        if (mod_done) begin
          next_state = AOCAL_ACCUM;
        end
      end
      AOCAL_ACCUM: begin
        if (accum_done) begin
          next_state = AOCAL_STORE;
        end
      end
      AOCAL_STORE: begin
        next_state = AOCAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      start_sync <= 3'h0;
      start_level <= 1'b0;
    end else begin
      start_sync <= {start_sync[1:0], start_pin};
      if (start_sync[1] == start_sync[2]) begin
        start_level <= start_sync[2];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= AOCAL_IDLE;
      cal_kind <= AOCAL_CMD_NONE;
    end else begin
      state <= next_state;
      if (state == AOCAL_IDLE && any_cmd) begin
        cal_kind <= system_gain_cal_cmd ? AOCAL_CMD_SYS_GAIN :
          internal_offset_cal_cmd ? AOCAL_CMD_SELF_OFS :
          AOCAL_CMD_SYS_OFS;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt <= 6'h00;
      mod_cnt <= 6'h00;
      conv_cnt <= 5'h00;
      acc <= 20'sh0_0000;
    end else begin
      settle_cnt <= (state == AOCAL_SETTLE) ? settle_cnt + 6'h01 : 6'h00;
      if (state != AOCAL_MOD) begin
        mod_cnt <= 6'h00;
      end else if (mod_tick) begin
        mod_cnt <= mod_cnt + 6'h01;
      end
      if (state != AOCAL_ACCUM) begin
        conv_cnt <= 5'h00;
        acc <= 20'sh0_0000;
      end else if (filt_valid) begin
        conv_cnt <= conv_cnt + 5'h01;
        acc <= acc + 20'(signed'(filt_data));
      end
    end
  end

  // latch the store value and load strobes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cal_value <= 24'h00_0000;
      cal_ofs_load <= 1'b0;
      cal_gain_load <= 1'b0;
    end else begin
      cal_ofs_load <= 1'b0;
      cal_gain_load <= 1'b0;
      if (state == AOCAL_ACCUM && accum_done) begin
        if (cal_kind == AOCAL_CMD_SYS_GAIN) begin
          cal_value <= gain_value;
          cal_gain_load <= 1'b1;
        end else begin
          cal_value <= {avg, 8'h00};
          cal_ofs_load <= 1'b1;
        end
      end
    end
  end

  // stop or sleep during calibration is deferred until the end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pd_pending <= 1'b0;
      power_down <= 1'b0;
    end else begin
      if (state == AOCAL_STORE) begin
        pd_pending <= 1'b0;
        power_down <= pd_pending | ~start_level;
      end else if (calibrating) begin
        if (sleep_cmd || start_fall) begin
          pd_pending <= 1'b1;
        end
      end else if (sleep_cmd || start_fall) begin
        power_down <= 1'b1;
      end else if (!start_level && start_sync[1] && start_sync[2]) begin
        // only a rising start wakes; a steady high keeps sleep
        power_down <= 1'b0;
      end
    end
  end

  // ready falls at calibration end; set beats clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      conversion_ready_n <= 1'b1;
    end else if (state == AOCAL_STORE
        || (!calibrating && scaled_valid)) begin
      conversion_ready_n <= 1'b0;
    end else if (ready_clear) begin
      conversion_ready_n <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      result_valid <= 1'b0;
      result_data <= 16'h0000;
    end else begin
      result_valid <= scaled_valid && !calibrating;
      if (scaled_valid && !calibrating) begin
        result_data <= scaled_data;
      end
    end
  end

  assign filt_restart = state == AOCAL_IDLE && any_cmd;
  assign input_short_mid = calibrating
    && cal_kind == AOCAL_CMD_SELF_OFS;
  assign cal_busy = calibrating;

  aocal_regs u_regs (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .reg_wr(reg_wr && !calibrating),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .cal_ofs_load(cal_ofs_load),
    .cal_gain_load(cal_gain_load),
    .cal_value(cal_value),
    .offset_correction_word(offset_correction_word),
    .gain_correction_word(gain_correction_word)
  );

  aocal_scaler u_scaler (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(filt_valid),
    .in_data(filt_data),
    .offset_correction_word(offset_correction_word),
    .gain_correction_word(gain_correction_word),
    .out_valid(scaled_valid),
    .out_data(scaled_data)
  );
endmodule : aocal_top

//--- dv/aocal_chk.sv
module aocal_chk #(
  parameter int MOD_DIV = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic system_offset_cal_cmd,
  input wire logic internal_offset_cal_cmd,
  input wire logic system_gain_cal_cmd,
  input wire logic filt_valid,
  input wire logic ready_clear,
  input wire logic filt_restart,
  input wire logic input_short_mid,
  input wire logic cal_busy,
  input wire logic power_down,
  input wire logic result_valid,
  input wire logic conversion_ready_n
);
  wire any_cmd = system_offset_cal_cmd | internal_offset_cal_cmd |
    system_gain_cal_cmd;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  property p_take;
    !cal_busy && any_cmd |=> cal_busy;
  endproperty
  a_take: assert property (p_take) else $error("cmd not taken");
  property p_restart;
    !cal_busy && any_cmd |-> filt_restart;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  property p_result;
    filt_valid && !cal_busy && !any_cmd ##1 !cal_busy |=> result_valid;
  endproperty
  a_result: assert property (p_result) else $error("no result");
  property p_ready;
    $fell(cal_busy) |-> ##[0:2] !conversion_ready_n;
  endproperty
  a_ready: assert property (p_ready) else $error("ready late");
  property p_hold;
    !conversion_ready_n && !ready_clear |=> !conversion_ready_n;
  endproperty
  a_hold: assert property (p_hold) else $error("ready dropped");
  property p_clear;
    ready_clear && !cal_busy && !$past(filt_valid) |=> conversion_ready_n;
  endproperty
  a_clear: assert property (p_clear) else $error("clear lost");
  property p_short;
    input_short_mid |-> cal_busy;
  endproperty
  a_short: assert property (p_short) else $error("short idle");
  property p_pd;
    cal_busy && $past(cal_busy) |-> $stable(power_down);
  endproperty
  a_pd: assert property (p_pd) else $error("early sleep");
  property p_len;
    $rose(cal_busy) |-> cal_busy [*8];
  endproperty
  a_len: assert property (p_len) else $error("cal too short");
  c_cal: cover property ($fell(cal_busy));
  c_short: cover property (input_short_mid);
  c_pd: cover property ($rose(power_down));
endmodule : aocal_chk

//--- dv/aocal_host_model.sv
module aocal_host_model (
  input wire logic clk_sys,
  input wire logic cal_busy,
  input wire logic slow,
  input wire logic [15:0] level,
  output logic [2:0] cmd,
  output logic mod_tick,
  output logic filt_valid,
  output logic [15:0] filt_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial begin
    cmd = 3'h0;
    mod_tick = 1'b0;
    filt_valid = 1'b0;
    filt_data = 16'h0000;
  end
  // data line inverts every cycle between samples
  always @(negedge clk_sys) begin
    cnt <= cnt + 1;
    mod_tick <= slow ? cnt[0] : 1'b1;
    filt_valid <= (cnt % (slow ? 8 : 4)) == 0;
    filt_data <= ((cnt % (slow ? 8 : 4)) == 0) ? level : ~filt_data;
  end
  task automatic issue(input int k);
    while (cal_busy) @(negedge clk_sys);
    @(negedge clk_sys);
    cmd = 3'(1 << k);
    @(negedge clk_sys);
    cmd = 3'h0;
  endtask : issue
endmodule : aocal_host_model

//--- dv/test_adc_offset_gain_calibration.sv
`define CHK(a, b) \
  begin \
    num_checks++; \
    if ((a) !== (b)) begin \
      error_cnt++; \
      $display("BAD %0t got %h want %h", $time, a, b); \
    end \
  end
module test_adc_offset_gain_calibration;
  timeunit 1ns;
  timeprecision 1ps;
  import aocal_pkg::*;
  logic clk_sys, rst_n, reg_wr, sleep_cmd, start_pin, ready_clear, slow;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [15:0] level, result_data, filt_data, d, o, r;
  logic [2:0] cmd;
  logic [23:0] w, g;
  logic mod_tick, filt_valid, filt_restart, input_short_mid, cal_busy;
  logic power_down, result_valid, conversion_ready_n;
  int error_cnt = 0;
  int num_checks = 0;
  int seed = 92;
  logic [23:0] ofs_tab [5] = '{24'h00_0000, 24'h00_0100, 24'hff_ff00,
    24'h80_0000, 24'h7f_ffff};
  logic [15:0] r4_tab [5] = '{16'h0000, 16'hffff, 16'h0001, 16'h7fff,
    16'h8000};
  logic [23:0] g_tab [3] = '{24'h80_0000, 24'h20_0000, 24'h00_0000};
  logic [15:0] g_res [3] = '{16'h2468, 16'h091a, 16'h0000};
  aocal_top #(.MOD_DIV(1)) aocal_top_inst (
    .clk_sys, .rst_n, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
    .system_offset_cal_cmd(cmd[0]), .internal_offset_cal_cmd(cmd[1]),
    .system_gain_cal_cmd(cmd[2]), .sleep_cmd, .start_pin, .mod_tick,
    .filt_valid, .filt_data, .filt_restart, .input_short_mid, .cal_busy,
    .power_down, .result_valid, .result_data, .conversion_ready_n,
    .ready_clear
  );
  aocal_host_model aocal_host_model_inst (
    .clk_sys, .cal_busy, .slow, .level, .cmd, .mod_tick, .filt_valid,
    .filt_data
  );
  function automatic logic [15:0] expect_res(input logic [15:0] x,
      input logic [23:0] ofs, input logic [23:0] gw);
    longint v;
    v = longint'($signed(x)) - longint'($signed(ofs[23:8]));
    v = (v * longint'(gw)) >>> GAIN_FRAC_BITS;
    if (v > 32767) v = 32767;
    if (v < -32768) v = -32768;
    return 16'(v);
  endfunction : expect_res
  task automatic wr(input logic [2:0] a, input logic [7:0] x);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = x;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask : wr
  task automatic wr_word(input logic [2:0] a, input logic [23:0] x);
    for (int i = 0; i < 3; i++) wr(3'(a + i), x[8*i+:8]);
  endtask : wr_word
  task automatic rd_word(input logic [2:0] a);
    for (int i = 0; i < 3; i++) begin
      @(negedge clk_sys);
      reg_addr = 3'(a + i);
      #1 w[8*i+:8] = reg_rdata;
    end
  endtask : rd_word
  task automatic sample(input logic [15:0] lv);
    int n;
    @(negedge clk_sys);
    level = lv;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(negedge clk_sys);
        n++;
      end while (!result_valid && n < 100);
    end
    `CHK(result_valid, 1'b1);
    r = result_data;
  endtask : sample
  task automatic cal(input int k);
    int n = 0;
    aocal_host_model_inst.issue(k);
    `CHK(input_short_mid, 1'(k == 1));
    if (k == 2) begin
      wr(OFS_HIGH_ADDR, 8'h55);
      sleep_cmd = 1'b1;
      @(negedge clk_sys);
      sleep_cmd = 1'b0;
      `CHK(power_down, 1'b0);
    end
    while (cal_busy && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK(cal_busy, 1'b0);
    repeat (2) @(negedge clk_sys);
    `CHK(conversion_ready_n, 1'b0);
    @(posedge clk_sys);
    while (filt_valid) @(posedge clk_sys);
    @(negedge clk_sys);
    ready_clear = 1'b1;
    @(negedge clk_sys);
    ready_clear = 1'b0;
    `CHK(conversion_ready_n, 1'b1);
  endtask : cal
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    #(CLK_SYS_PERIOD_NS * 60000);
    error_cnt++;
    conclude();
  end
  initial begin
    {rst_n, reg_wr, sleep_cmd, ready_clear, slow} = 5'h0_0;
    {reg_addr, reg_wdata, level, start_pin} = {3'h0, 8'h00, 16'h0000, 1'b1};
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    rd_word(OFS_LOW_ADDR);
    `CHK(w, OFS_RESET);
    rd_word(GAIN_LOW_ADDR);
    `CHK(w, 24'h40_0000);
    wr(3'h7, 8'hff);
    #1 `CHK(reg_rdata, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr_word(OFS_LOW_ADDR, ofs_tab[i]);
      sample(16'h0000);
      `CHK(r, r4_tab[i]);
    end
    wr_word(OFS_LOW_ADDR, 24'h00_0000);
    for (int i = 0; i < 3; i++) begin
      wr_word(GAIN_LOW_ADDR, g_tab[i]);
      sample(16'h1234);
      `CHK(r, g_res[i]);
    end
    for (int i = 0; i < 20; i++) begin
      o = 16'($random(seed));
      d = 16'($random(seed));
      g = ($random(seed) & 1) ? 24'h80_0000 : GAIN_UNITY;
      wr_word(OFS_LOW_ADDR, {o, 8'h00});
      wr_word(GAIN_LOW_ADDR, g);
      sample(d);
      `CHK(r, expect_res(d, {o, 8'h00}, g));
    end
    wr_word(GAIN_LOW_ADDR, GAIN_UNITY);
    slow = 1'b1;
    level = 16'h0005;
    cal(0);
    slow = 1'b0;
    rd_word(OFS_LOW_ADDR);
    `CHK(w, 24'h00_0500);
    sample(16'h0005);
    `CHK(r, 16'h0000);
    level = 16'h0000;
    cal(1);
    rd_word(OFS_LOW_ADDR);
    `CHK(w, 24'h00_0000);
    level = 16'h4000;
    cal(2);
    rd_word(GAIN_LOW_ADDR);
    `CHK(w, 24'h7f_ff00);
    rd_word(OFS_LOW_ADDR);
    `CHK(w, 24'h00_0000);
    `CHK(power_down, 1'b1);
    conclude();
  end
endmodule : test_adc_offset_gain_calibration
bind aocal_top aocal_chk #(.MOD_DIV(MOD_DIV)) aocal_chk_inst (
  .clk_sys, .rst_n, .system_offset_cal_cmd, .internal_offset_cal_cmd,
  .system_gain_cal_cmd, .filt_valid, .ready_clear, .filt_restart,
  .input_short_mid, .cal_busy, .power_down, .result_valid,
  .conversion_ready_n
);
